// ===== rtl/lpm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl
#(
  parameter int NPINS = lpm_pkg::NUM_WAKE_PINS,
  parameter int DEBOUNCE = lpm_pkg::DEBOUNCE_CYC,
  parameter int BACKUP_SETTLE = lpm_pkg::SUPPLY_UP_CYC
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic deep_sleep_select,
  input wire logic regulator_off_request,
  input wire logic wait_mode_request,
  input wire logic [1:0] flash_low_power_select,
  input wire logic low_power_select,
  input wire logic wait_for_interrupt_instruction,
  input wire logic irq_pending,
  input wire logic slow_osc_xtal_select,
  input wire logic regulator_disable,
  input wire logic [1:0] master_clock_source,
  input wire logic [lpm_pkg::PERIPH_CLKS-1:0] periph_clock_enable,
  input wire logic [NPINS-1:0] wake_pins,
  input wire logic [NPINS-1:0] wake_pin_enables,
  input wire logic [NPINS-1:0] fast_startup_enables,
  input wire logic supply_monitor_alarm,
  input wire logic supply_monitor_wake_enable,
  input wire logic calendar_alarm,
  input wire logic calendar_wake_enable,
  input wire logic real_time_timer_alarm,
  input wire logic real_time_timer_wake_enable,
  output logic cpu_clock_en,
  output logic [lpm_pkg::PERIPH_CLKS-1:0] periph_clock_en,
  output logic mem_clock_en,
  output logic [1:0] master_clock_sel,
  output logic fast_rc_on,
  output logic slow_osc_xtal_on,
  output logic slow_osc_rc_on,
  output logic regulator_on,
  output logic core_supply_on,
  output logic sram_supply_on,
  output logic [1:0] flash_state,
  output logic pins_hold,
  output logic pins_reset_pullup,
  output logic cpu_reset,
  output logic master_clock_ready,
  output logic [2:0] mode_state
);
  typedef enum {ST_ACTIVE, ST_SLEEP, ST_WAIT, ST_WAIT_WAKE, ST_BACKUP, ST_BACKUP_WAKE} lpm_state_t;

  lpm_state_t state_reg;
  logic [15:0] cnt_reg;
  logic [NPINS-1:0] pin_level;
  logic [NPINS-1:0] pin_prev_reg;
  logic [1:0] flp_reg;
  logic pin_change;
  logic pin_low;
  logic alarm_wake;
  logic backup_wake;
  logic wait_wake;
  logic [15:0] wait_settle;

  initial
  begin
    if (NPINS < 1 || NPINS > 32)
      $error("pin count out of range");
    if (BACKUP_SETTLE < 1 || BACKUP_SETTLE >= lpm_pkg::WAKE_BACKUP_CYC)
      $error("backup settle breaks latency");
  end

  // ****************************************************************
  // wake pin conditioning
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++)
    begin : g_pin
      lpm_wake_filter #(.DEBOUNCE(DEBOUNCE)) u_filt
      (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin(wake_pins[gi]),
        .level(pin_level[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pin_prev_reg <= '1;
    else
      pin_prev_reg <= pin_level;
  end

  always_comb
  begin
    pin_change = |((pin_level ^ pin_prev_reg) & wake_pin_enables);
    pin_low = |(~pin_level & fast_startup_enables);
    alarm_wake = (calendar_alarm & calendar_wake_enable)
               | (real_time_timer_alarm & real_time_timer_wake_enable);
    backup_wake = pin_change | alarm_wake
                | (supply_monitor_alarm & supply_monitor_wake_enable);
    wait_wake = pin_low | alarm_wake;
    // flash recovery time picked by mode
    wait_settle = (flp_reg == lpm_pkg::FLASH_DEEP_PD) ? 16'(lpm_pkg::FLASH_DEEP_CYC)
                                                    : 16'(lpm_pkg::RC_START_CYC);
  end

  // ****************************************************************
  // mode sequencer
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_ACTIVE;
      cnt_reg <= 16'h0000;
      flp_reg <= lpm_pkg::FLASH_STANDBY;
    end
    else
    begin
      unique case (state_reg)
        ST_ACTIVE:
        begin
          cnt_reg <= 16'h0000;
          if (deep_sleep_select && regulator_off_request)
            state_reg <= ST_BACKUP;
          else if (wait_mode_request && !deep_sleep_select
                   && flash_low_power_select[1] == 1'b0)
          begin
            flp_reg <= flash_low_power_select;
            state_reg <= ST_WAIT;
          end
          else if (wait_for_interrupt_instruction && !deep_sleep_select
                   && !low_power_select)
            state_reg <= ST_SLEEP;
        end
        ST_SLEEP:
          if (irq_pending)
            state_reg <= ST_ACTIVE;
        ST_WAIT:
          if (wait_wake)
            state_reg <= ST_WAIT_WAKE;
        ST_WAIT_WAKE:
          if (cnt_reg >= wait_settle - 16'h0001)
            state_reg <= ST_ACTIVE;
          else
            cnt_reg <= cnt_reg + 16'h0001;
        ST_BACKUP:
          if (backup_wake)
            state_reg <= ST_BACKUP_WAKE;
        // supplies come up, then reset released
        ST_BACKUP_WAKE:
          if (cnt_reg >= 16'(BACKUP_SETTLE - 1))
            state_reg <= ST_ACTIVE;
          else
            cnt_reg <= cnt_reg + 16'h0001;
      endcase
    end
  end

  // ****************************************************************
  // clock gating and clock source
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cpu_clock_en <= 1'b1;
      mem_clock_en <= 1'b1;
      periph_clock_en <= lpm_pkg::PERIPH_EN_RESET;
      master_clock_sel <= lpm_pkg::CLK_FAST_RC;
      fast_rc_on <= 1'b1;
    end
    else
    begin
      // sleep only stops the cpu; wait stops everything
      cpu_clock_en <= (state_reg == ST_ACTIVE);
      mem_clock_en <= (state_reg == ST_ACTIVE) || (state_reg == ST_SLEEP);
      periph_clock_en <= ((state_reg == ST_ACTIVE) || (state_reg == ST_SLEEP))
                         ? periph_clock_enable : '0;
      fast_rc_on <= (state_reg != ST_WAIT) && (state_reg != ST_BACKUP);
      // wake lands on fast RC; software may move on later
      if (state_reg == ST_WAIT_WAKE || state_reg == ST_BACKUP_WAKE)
        master_clock_sel <= lpm_pkg::CLK_FAST_RC;
      else if (state_reg == ST_ACTIVE)
        master_clock_sel <= (master_clock_source == 2'h3) ? lpm_pkg::CLK_PLL
                                                          : master_clock_source;
    end
  end

  // ****************************************************************
  // supplies, slow oscillator, pins, reset
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      regulator_on <= 1'b1;
      core_supply_on <= 1'b1;
      sram_supply_on <= 1'b1;
      slow_osc_xtal_on <= 1'b0;
      slow_osc_rc_on <= 1'b1;
      pins_hold <= 1'b0;
      pins_reset_pullup <= 1'b1;
      cpu_reset <= 1'b1;
    end
    else
    begin
      // regulator off in backup or by request
      regulator_on <= (state_reg != ST_BACKUP) && !regulator_disable;
      core_supply_on <= (state_reg != ST_BACKUP);
      sram_supply_on <= (state_reg != ST_BACKUP);
      // one slow oscillator by software choice
      slow_osc_xtal_on <= slow_osc_xtal_select;
      slow_osc_rc_on <= !slow_osc_xtal_select;
      // hold pins in backup and until reset done
      pins_hold <= (state_reg == ST_BACKUP) || (state_reg == ST_BACKUP_WAKE);
      // pins come up as pulled-up inputs after backup reset
      if (state_reg == ST_BACKUP_WAKE)
        pins_reset_pullup <= 1'b1;
      else if (state_reg == ST_ACTIVE && !cpu_reset)
        pins_reset_pullup <= 1'b0;
      cpu_reset <= (state_reg == ST_BACKUP) || (state_reg == ST_BACKUP_WAKE);
    end
  end

  // ****************************************************************
  // flash state, ready flag, status
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      flash_state <= lpm_pkg::FST_ACTIVE;
      master_clock_ready <= 1'b1;
      mode_state <= 3'h0;
    end
    else
    begin
      if (state_reg == ST_WAIT)
        unique case (flp_reg)
          lpm_pkg::FLASH_STANDBY: flash_state <= lpm_pkg::FST_STANDBY;
          lpm_pkg::FLASH_DEEP_PD: flash_state <= lpm_pkg::FST_DEEP_PD;
          default: flash_state <= lpm_pkg::FST_IDLE;
        endcase
      else
        flash_state <= lpm_pkg::FST_ACTIVE;
      // ready low in wait, backup and both wake sequences, high in active or sleep
      master_clock_ready <= (state_reg == ST_ACTIVE) || (state_reg == ST_SLEEP);
      mode_state <= 3'(state_reg);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/lpm_pkg.sv
package lpm_pkg;
  // ****************************************************************
  // flash low-power select encodings
  // ****************************************************************
  localparam logic [1:0] FLASH_STANDBY = 2'h0;
  localparam logic [1:0] FLASH_DEEP_PD = 2'h1;
  localparam logic [1:0] FLASH_IDLE = 2'h2;
  // flash state outputs
  localparam logic [1:0] FST_ACTIVE = 2'h0;
  localparam logic [1:0] FST_STANDBY = 2'h1;
  localparam logic [1:0] FST_DEEP_PD = 2'h2;
  localparam logic [1:0] FST_IDLE = 2'h3;
  // master clock source select
  localparam logic [1:0] CLK_FAST_RC = 2'h0;
  localparam logic [1:0] CLK_MAIN_XTAL = 2'h1;
  localparam logic [1:0] CLK_PLL = 2'h2;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ = 40000000;
  localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  localparam int WAKE_STANDBY_NS = 10000;
  localparam int WAKE_DEEP_PD_NS = 100000;
  localparam int WAKE_BACKUP_NS = 1000000;
  // longest times round down
  localparam int WAKE_STANDBY_CYC = WAKE_STANDBY_NS / CLK_PERIOD_NS;
  localparam int WAKE_DEEP_PD_CYC = WAKE_DEEP_PD_NS / CLK_PERIOD_NS;
  localparam int WAKE_BACKUP_CYC = WAKE_BACKUP_NS / CLK_PERIOD_NS;
  // settle cycles used by each wake sequence (well inside the limits)
  localparam int RC_START_CYC = 8;
  localparam int FLASH_DEEP_CYC = 64;
  localparam int SUPPLY_UP_CYC = 256;
  localparam int DEBOUNCE_CYC = 4;
  localparam int NUM_WAKE_PINS = 16;
  localparam int PERIPH_CLKS = 8;
  localparam logic [7:0] PERIPH_EN_RESET = 8'hff;
endpackage

// ===== rtl/lpm_wake_filter.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// pin synchroniser and debouncer for one wake pin
// ****************************************************************
module lpm_wake_filter
#(
  parameter int DEBOUNCE = 4
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin,
  output logic level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic [15:0] cnt_reg;

  initial
  begin
    if (DEBOUNCE < 1 || DEBOUNCE > 65535)
      $error("debounce out of range");
  end

  // three-flop chain; s1 only feeds s2
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end
    else
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // level accepted after s2/s3 agree and differ for DEBOUNCE cycles
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      level <= 1'b1;
      cnt_reg <= 16'h0000;
    end
    else if (s2_reg == s3_reg && s3_reg != level)
    begin
      if (cnt_reg == 16'(DEBOUNCE - 1))
      begin
        level <= s3_reg;
        cnt_reg <= 16'h0000;
      end
      else
        cnt_reg <= cnt_reg + 16'h0001;
    end
    else
      cnt_reg <= 16'h0000;
  end
endmodule
`default_nettype wire

// ===== sim/lpm_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// mode sequencing checks
// ****************************************************************
module lpm_ctrl_checker
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic deep_sleep_select,
  input wire logic regulator_off_request,
  input wire logic wait_mode_request,
  input wire logic [1:0] flash_low_power_select,
  input wire logic cpu_clock_en,
  input wire logic [lpm_pkg::PERIPH_CLKS-1:0] periph_clock_en,
  input wire logic mem_clock_en,
  input wire logic [1:0] master_clock_sel,
  input wire logic fast_rc_on,
  input wire logic slow_osc_xtal_on,
  input wire logic slow_osc_rc_on,
  input wire logic regulator_on,
  input wire logic core_supply_on,
  input wire logic sram_supply_on,
  input wire logic [1:0] flash_state,
  input wire logic pins_hold,
  input wire logic cpu_reset,
  input wire logic master_clock_ready,
  input wire logic [2:0] mode_state
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // seen twice in active, so the state was active when the request was taken
  sequence s_backup_req;
    mode_state == 3'h0 && deep_sleep_select && regulator_off_request;
  endsequence
  sequence s_wait_req;
    mode_state == 3'h0 && wait_mode_request && !deep_sleep_select && !flash_low_power_select[1];
  endsequence
  a_backup_entry:
  assert property (s_backup_req ##1 s_backup_req |-> ##1 mode_state == 3'h4)
    else $error("backup request not taken");
  a_wait_entry:
  assert property (s_wait_req ##1 s_wait_req |-> ##1 mode_state == 3'h2)
    else $error("wait request not taken");
  a_wait_clocks:
  assert property (mode_state == 3'h2 |-> !cpu_clock_en && !mem_clock_en &&
    periph_clock_en == '0 && !master_clock_ready && core_supply_on && regulator_on)
    else $error("wait clocks or supplies wrong");
  a_wait_flash:
  assert property (mode_state == 3'h2 |-> flash_state ==
    (flash_low_power_select[0] ? lpm_pkg::FST_DEEP_PD : lpm_pkg::FST_STANDBY))
    else $error("flash state wrong in wait");
  a_wake_restart:
  assert property ($past(mode_state) == 3'h3 && mode_state == 3'h0 |->
    cpu_clock_en && master_clock_ready && fast_rc_on && master_clock_sel == lpm_pkg::CLK_FAST_RC)
    else $error("wait wake not on fast rc");
  a_wait_rc_off:
  assert property (mode_state == 3'h2 |-> !fast_rc_on)
    else $error("fast rc left running in wait");
  a_slow_osc_one:
  assert property (slow_osc_xtal_on != slow_osc_rc_on)
    else $error("slow oscillator choice wrong");
  a_backup_off:
  assert property (mode_state == 3'h4 |-> !regulator_on && !core_supply_on && pins_hold && cpu_reset)
    else $error("backup supplies or pins wrong");
  a_sleep_clock:
  assert property (mode_state == 3'h1 |-> !cpu_clock_en && regulator_on && core_supply_on)
    else $error("sleep clocks wrong");
  a_backup_supply:
  assert property (mode_state == 3'h5 |-> core_supply_on && sram_supply_on)
    else $error("supplies not back on wake");
endmodule
bind lpm_ctrl lpm_ctrl_checker u_chk
(
  .clk, .sys_rst, .deep_sleep_select, .regulator_off_request, .wait_mode_request,
  .flash_low_power_select, .cpu_clock_en, .periph_clock_en, .mem_clock_en, .master_clock_sel,
  .fast_rc_on, .slow_osc_xtal_on, .slow_osc_rc_on,
  .regulator_on, .core_supply_on, .sram_supply_on, .flash_state, .pins_hold, .cpu_reset,
  .master_clock_ready, .mode_state
);
`default_nettype wire

// ===== sim/lpm_wake_src.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// wake sources: pins idle high as pulled-up inputs, alarms idle low
// ****************************************************************
module lpm_wake_src
(
  output logic [15:0] wake_pins,
  output logic [2:0] alarms
);
  initial
    {wake_pins, alarms} = {16'hffff, 3'h0};
  task automatic set_pins(input logic [15:0] v);
    wake_pins = v;
  endtask
  task automatic set_alarms(input logic [2:0] a);
    alarms = a;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// mode sequencing bench
// ****************************************************************
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic deep_sleep_select, regulator_off_request, wait_mode_request, low_power_select;
  logic wait_for_interrupt_instruction, irq_pending, slow_osc_xtal_select, regulator_disable;
  logic supply_monitor_wake_enable, calendar_wake_enable, real_time_timer_wake_enable;
  logic [1:0] flash_low_power_select, master_clock_source, master_clock_sel, flash_state;
  logic [7:0] periph_clock_enable, periph_clock_en;
  logic [15:0] wake_pins, wake_pin_enables, fast_startup_enables;
  logic [2:0] alarms, mode_state;
  logic cpu_clock_en, mem_clock_en, slow_osc_xtal_on, regulator_on, core_supply_on;
  logic sram_supply_on, pins_hold, pins_reset_pullup, cpu_reset, master_clock_ready;
  logic fast_rc_on, slow_osc_rc_on;
  int n_errors = 0;
  int compares = 0;
  int i;
  // short settle and debounce keep the backup runs brief
  lpm_ctrl #(.BACKUP_SETTLE(4), .DEBOUNCE(1)) dut
  (
    .clk, .sys_rst, .deep_sleep_select, .regulator_off_request, .wait_mode_request,
    .flash_low_power_select, .low_power_select, .wait_for_interrupt_instruction, .irq_pending,
    .slow_osc_xtal_select, .regulator_disable, .master_clock_source, .periph_clock_enable,
    .wake_pins, .wake_pin_enables, .fast_startup_enables, .supply_monitor_alarm(alarms[2]),
    .supply_monitor_wake_enable, .calendar_alarm(alarms[1]), .calendar_wake_enable,
    .real_time_timer_alarm(alarms[0]), .real_time_timer_wake_enable, .cpu_clock_en,
    .periph_clock_en, .mem_clock_en, .master_clock_sel, .fast_rc_on, .slow_osc_xtal_on,
    .slow_osc_rc_on, .regulator_on, .core_supply_on, .sram_supply_on, .flash_state,
    .pins_hold, .pins_reset_pullup, .cpu_reset, .master_clock_ready, .mode_state
  );
  lpm_wake_src src (.wake_pins, .alarms);
  always #12.5 clk = ~clk;
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // bounded wait, sampled at falling edges where outputs have settled
  task automatic wait_mode(input logic [2:0] m, input int lim);
    for (int k = 0; k < lim && mode_state !== m; k++)
      @(negedge clk);
    chk(mode_state === m, "mode not reached");
  endtask
  task automatic conclude();
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles of the run
  initial
  begin
    #750000;
    n_errors++;
    conclude();
  end
  initial
  begin
    {deep_sleep_select, regulator_off_request, wait_mode_request, low_power_select} = '0;
    {wait_for_interrupt_instruction, irq_pending, slow_osc_xtal_select, regulator_disable} = '0;
    {supply_monitor_wake_enable, calendar_wake_enable, real_time_timer_wake_enable} = '0;
    {flash_low_power_select, master_clock_source, periph_clock_enable} = '0;
    {wake_pin_enables, fast_startup_enables} = '0;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(cpu_clock_en === 1'b1 && regulator_on === 1'b1 && mode_state === 3'h0, "reset");
    chk(fast_rc_on === 1'b1 && slow_osc_rc_on === 1'b1 && mem_clock_en === 1'b1, "osc");
    chk(cpu_reset === 1'b0 && pins_reset_pullup === 1'b0, "reset out");
    // code 3 also picks the pll
    master_clock_source = 2'h3;
    periph_clock_enable = 8'h0f;
    regulator_disable = 1'b1;
    repeat (3) @(negedge clk);
    chk(master_clock_sel === lpm_pkg::CLK_PLL && periph_clock_en === 8'h0f, "clk");
    chk(regulator_on === 1'b0 && mode_state === 3'h0, "regulator");
    master_clock_source = lpm_pkg::CLK_MAIN_XTAL;
    repeat (2) @(negedge clk);
    chk(master_clock_sel === lpm_pkg::CLK_MAIN_XTAL, "xtal");
    // software moves to fast rc before any wait request
    {regulator_disable, master_clock_source} = {1'b0, lpm_pkg::CLK_FAST_RC};
    flash_low_power_select = lpm_pkg::FLASH_IDLE;
    wait_mode_request = 1'b1;
    repeat (4) @(negedge clk);
    chk(mode_state === 3'h0, "idle select");
    // standby wakes by pin, deep power-down by timer, standby again by calendar
    for (i = 0; i < 3; i++)
    begin
      {flash_low_power_select, wait_mode_request} = {1'b0, i[0], 1'b1};
      wait_mode(3'h2, 10);
      wait_mode_request = 1'b0;
      chk(cpu_clock_en === 1'b0 && master_clock_ready === 1'b0, "wait");
      chk(mem_clock_en === 1'b0 && fast_rc_on === 1'b0, "wait clocks");
      chk(flash_state === (i[0] ? lpm_pkg::FST_DEEP_PD : lpm_pkg::FST_STANDBY), "fl");
      src.set_alarms(3'h7);
      src.set_pins(16'h0000);
      repeat (20) @(negedge clk);
      chk(mode_state === 3'h2, "disabled wake");
      src.set_alarms(3'h0);
      src.set_pins(16'hffff);
      // filters must see the pins high again, or a stale low wakes it
      repeat (6) @(negedge clk);
      fast_startup_enables = (i == 0) ? 16'h0008 : 16'h0000;
      real_time_timer_wake_enable = (i == 1);
      calendar_wake_enable = (i == 2);
      src.set_alarms({1'b0, i == 2, i == 1});
      src.set_pins((i == 0) ? 16'hfff7 : 16'hffff);
      wait_mode(3'h0, i[0] ? lpm_pkg::WAKE_DEEP_PD_CYC : lpm_pkg::WAKE_STANDBY_CYC);
      chk(master_clock_sel === lpm_pkg::CLK_FAST_RC && cpu_clock_en === 1'b1, "rc");
      chk(fast_rc_on === 1'b1 && master_clock_ready === 1'b1, "rc on");
      {fast_startup_enables, real_time_timer_wake_enable, calendar_wake_enable} = '0;
      src.set_pins(16'hffff);
      src.set_alarms(3'h0);
    end
    // low-power select keeps the wfi from sleeping
    {low_power_select, wait_for_interrupt_instruction} = 2'h3;
    repeat (4) @(negedge clk);
    chk(mode_state === 3'h0, "sleep refused");
    low_power_select = 1'b0;
    wait_mode(3'h1, 10);
    wait_for_interrupt_instruction = 1'b0;
    chk(cpu_clock_en === 1'b0 && periph_clock_en === 8'h0f, "sleep");
    chk(mem_clock_en === 1'b1, "sleep mem");
    irq_pending = 1'b1;
    wait_mode(3'h0, 10);
    irq_pending = 1'b0;
    // backup woken by pin toggle, then by supply monitor
    slow_osc_xtal_select = 1'b1;
    for (i = 0; i < 2; i++)
    begin
      deep_sleep_select = 1'b1;
      @(negedge clk);
      regulator_off_request = 1'b1;
      wait_mode(3'h4, 10);
      {deep_sleep_select, regulator_off_request} = '0;
      chk(core_supply_on === 1'b0 && pins_hold === 1'b1, "backup");
      chk(slow_osc_xtal_on === 1'b1 && slow_osc_rc_on === 1'b0, "slow osc");
      chk(regulator_on === 1'b0 && fast_rc_on === 1'b0, "backup off");
      src.set_pins(16'hfffe);
      src.set_alarms(3'h7);
      repeat (20) @(negedge clk);
      chk(mode_state === 3'h4, "disabled wake");
      wake_pin_enables = i ? 16'h0000 : 16'h0002;
      supply_monitor_wake_enable = i[0];
      src.set_pins(i ? 16'hfffe : 16'hfffc);
      wait_mode(3'h0, 64);
      chk(pins_reset_pullup === 1'b1, "pullup");
      repeat (3) @(negedge clk);
      chk(sram_supply_on === 1'b1 && cpu_reset === 1'b0 && pins_hold === 1'b0, "up");
      {wake_pin_enables, supply_monitor_wake_enable} = '0;
      src.set_pins(16'hffff);
      src.set_alarms(3'h0);
    end
    conclude();
  end
endmodule
`default_nettype wire
